// file: logic/mcmon_bit_engine.sv
/*
  Bit engine: start, stop, byte write and byte read on SCL and SDA.
  Assumes sda_in is already synchronised and that the slave never stretches SCL.
*/
`timescale 1ns/100ps
`default_nettype none
module mcmon_bit_engine
  import mcmon_pkg::*;
#(
  parameter int FS_LEN = FS_PH,
  parameter int HS_LEN = HS_PH
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Sequencer side
  mcmon_bit_if.eng bi
);
  if (FS_LEN < 8 || FS_LEN > 255 || HS_LEN < 8 || HS_LEN > 255) begin : g_bad
    $error("mcmon_bit_engine: phase length out of range");
  end

  logic       run_ff;
  mcmon_bop_t bop_ff;
  logic [7:0] cnt_ff;
  logic [1:0] ph_ff;
  logic [3:0] bit_ff;
  logic [8:0] sh_ff;
  logic       scl_ff;
  logic       sda_ff;
  logic       done_ff;
  logic       nxt_scl;
  logic       nxt_sda;

  wire [7:0] ph_len  = bi.hs ? 8'(HS_LEN) : 8'(FS_LEN);
  wire       step    = run_ff && (cnt_ff == 8'h00);
  wire       is_byte = (bop_ff == BOP_WBYTE) || (bop_ff == BOP_RBYTE);
  wire       bit_end = is_byte && (ph_ff == 2'd3);
  wire       last    = (bop_ff == BOP_START && ph_ff == 2'd3) ||
                       (bop_ff == BOP_STOP && ph_ff == 2'd2) ||
                       (bit_end && bit_ff == 4'd8);
  // Read bytes release SDA, then drive the ninth bit as our acknowledge
  wire [8:0] load    = (bi.bop == BOP_RBYTE) ? {8'hff, ~bi.ack_send} : {bi.tx, 1'b1};

  always_comb begin
    nxt_scl = scl_ff;
    nxt_sda = sda_ff;
    if (step) begin
      unique case (bop_ff)
        BOP_START: begin
          case (ph_ff)
            2'd0: nxt_sda = 1'b1;
            2'd1: nxt_scl = 1'b1;
            2'd2: nxt_sda = 1'b0;
            default: nxt_scl = 1'b0;
          endcase
        end
        BOP_STOP: begin
          case (ph_ff)
            2'd0: nxt_sda = 1'b0;
            2'd1: nxt_scl = 1'b1;
            default: nxt_sda = 1'b1;
          endcase
        end
        BOP_WBYTE, BOP_RBYTE: begin
          case (ph_ff)
            2'd0, 2'd3: nxt_scl = 1'b0;
            2'd1: nxt_sda = sh_ff[8];
            default: nxt_scl = 1'b1;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      run_ff  <= 1'b0;
      bop_ff  <= BOP_START;
      cnt_ff  <= 8'h00;
      ph_ff   <= 2'd0;
      bit_ff  <= 4'h0;
      sh_ff   <= 9'h1ff;
      scl_ff  <= 1'b1;
      sda_ff  <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      scl_ff  <= nxt_scl;
      sda_ff  <= nxt_sda;
      done_ff <= step && last;
      if (!run_ff) begin
        if (bi.req) begin
          run_ff <= 1'b1;
          bop_ff <= bi.bop;
          cnt_ff <= 8'h00;
          ph_ff  <= 2'd0;
          bit_ff <= 4'h0;
          sh_ff  <= load;
        end
      end else if (!step) begin
        cnt_ff <= cnt_ff - 8'h01;
      end else begin
        cnt_ff <= ph_len;
        if (last) begin
          run_ff <= 1'b0;
        end else if (bit_end) begin
          ph_ff  <= 2'd1;
          bit_ff <= bit_ff + 4'h1;
        end else begin
          ph_ff <= ph_ff + 2'd1;
        end
        if (bit_end) begin
          sh_ff <= {sh_ff[7:0], bi.sda_in};
        end
      end
    end
  end

  assign bi.done     = done_ff;
  assign bi.rx       = sh_ff[8:1];
  assign bi.ack_seen = ~sh_ff[0];
  assign bi.scl_rel  = scl_ff;
  assign bi.sda_rel  = sda_ff;

  a_start_shape: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    ($fell(sda_ff) && scl_ff) |-> (bop_ff == BOP_START))
    else $error("SDA fell with SCL high outside a start");
  a_sda_steady: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    ($changed(sda_ff) && scl_ff && $past(scl_ff)) |-> !is_byte)
    else $error("SDA changed while SCL high in a data bit");
  a_scl_high_min: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    $rose(scl_ff) |=> scl_ff [*8])
    else $error("SCL high period too short");
  a_done_pulse: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    done_ff |=> !done_ff && !run_ff)
    else $error("Done longer than one cycle");
endmodule
`default_nettype wire

// file: logic/mcmon_bit_if.sv
/*
  Link between the transaction sequencer and the bit engine.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface mcmon_bit_if;
  import mcmon_pkg::*;
  logic       req;
  mcmon_bop_t bop;
  logic       hs;
  logic [7:0] tx;
  logic       ack_send;
  logic       sda_in;
  logic       done;
  logic [7:0] rx;
  logic       ack_seen;
  logic       scl_rel;
  logic       sda_rel;
  modport eng (input req, bop, hs, tx, ack_send, sda_in,
               output done, rx, ack_seen, scl_rel, sda_rel);
  modport seq (output req, bop, hs, tx, ack_send, sda_in,
               input done, rx, ack_seen, scl_rel, sda_rel);
endinterface
`default_nettype wire

// file: logic/mcmon_i2c_host.sv
/*
  Two-wire host for a current and power monitor: register access, pointer
  writes, word reads, high-speed entry and alert response polling.
  Assumes an Avalon-MM master on the system clock and external pullups on
  SCL and SDA; the monitor never stretches SCL.
*/
// Register access over Avalon-MM is this design's own decision.
// How it works
// - First byte after write address loads pointer
// - Every write carries a pointer byte
// - Address, pointer, two data bytes, all acknowledged
// - Write ends with start or stop
// - Pointer write, repeated start, then read address
// - Upper byte first, acknowledged, then lower byte
// - Host may end read with not-acknowledge
// - Master code sent at fast rate first
// - After repeated start, normal protocol, faster clock
// - Stop ends high-speed mode; repeated starts keep it
`timescale 1ns/100ps
`default_nettype none
module mcmon_i2c_host
  import mcmon_pkg::*;
#(
  parameter int FS_LEN = FS_PH,
  parameter int HS_LEN = HS_PH
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Serial pins, open drain
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o
);
  typedef enum {S_IDLE, S_HSSTART, S_HSCODE, S_START, S_ADDR, S_PTR,
                S_WHI, S_WLO, S_RHI, S_RLO, S_STOP} mcmon_st_t;

  mcmon_bit_if bi ();

  mcmon_bit_engine #(
    .FS_LEN (FS_LEN),
    .HS_LEN (HS_LEN)
  ) u_engine (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .bi        (bi.eng)
  );

  mcmon_st_t   state_ff;
  mcmon_st_t   nxt_state;
  logic        wait_ff;
  mcmon_op_t   op_ff;
  logic        hs_req_ff;
  logic        hold_ff;
  logic        lastack_ff;
  logic [6:0]  addr_ff;
  logic [7:0]  ptr_ff;
  logic [2:0]  hsc_ff;
  logic [15:0] wdata_ff;
  logic [15:0] rdata_ff;
  logic        nack_ff;
  logic        hs_ff;
  logic        held_ff;
  logic        ack_ff;
  logic [31:0] readdata_ff;
  logic        sda_s1_ff;
  logic        sda_s2_ff;
  logic        scl_s1_ff;
  logic        scl_s2_ff;

  // Bus slave: one wait cycle, then the access completes
  wire acc    = (avs_read_i || avs_write_i) && ack_ff;
  wire wr_acc = acc && avs_write_i;
  wire wr_ctl = wr_acc && (avs_address_i == REG_CTRL) && avs_byteenable_i[0];
  wire wr_tgt = wr_acc && (avs_address_i == REG_TARGET);
  wire wr_dat = wr_acc && (avs_address_i == REG_WDATA);
  wire wr_st  = wr_acc && (avs_address_i == REG_STATUS) && avs_byteenable_i[0];
  wire idle   = (state_ff == S_IDLE);
  // A start request while busy is ignored
  wire go     = wr_ctl && avs_writedata_i[CTRL_GO] && idle;
  wire busy   = !idle;

  wire [31:0] ctrl_rd = {26'h0, lastack_ff, hold_ff, hs_req_ff, op_ff, 1'b0};
  wire [31:0] tgt_rd  = {13'h0, hsc_ff, ptr_ff, 1'b0, addr_ff};
  wire [31:0] st_rd   = {26'h0, scl_s2_ff, sda_s2_ff, held_ff, hs_ff, nack_ff, busy};
  wire [31:0] rd_mux  = (avs_address_i == REG_CTRL)   ? ctrl_rd :
                        (avs_address_i == REG_TARGET) ? tgt_rd :
                        (avs_address_i == REG_WDATA)  ? {16'h0, wdata_ff} :
                        (avs_address_i == REG_RDATA)  ? {16'h0, rdata_ff} :
                        (avs_address_i == REG_STATUS) ? st_rd : 32'h0;

  // Sequencer decode
  wire dir_rd  = (op_ff == OP_READ) || (op_ff == OP_ALERT);
  wire [6:0] slave = (op_ff == OP_ALERT) ? ARA_ADDR : addr_ff;
  wire done    = bi.done;
  wire nak     = !bi.ack_seen;
  wire wbyte   = (state_ff == S_ADDR) || (state_ff == S_PTR) ||
                 (state_ff == S_WHI) || (state_ff == S_WLO);
  wire set_nak = done && wbyte && nak;
  wire stop_dn = done && (state_ff == S_STOP);
  // Holding the bus skips the stop so the next start is a repeated one
  mcmon_st_t end_st;
  assign end_st = hold_ff ? S_IDLE : S_STOP;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      S_IDLE:    if (go) nxt_state = (avs_writedata_i[CTRL_HS] && !hs_ff) ? S_HSSTART : S_START;
      S_HSSTART: if (done) nxt_state = S_HSCODE;
      S_HSCODE:  if (done) nxt_state = S_START;
      S_START:   if (done) nxt_state = S_ADDR;
      S_ADDR:    if (done) nxt_state = nak ? S_STOP : (dir_rd ? S_RHI : S_PTR);
      S_PTR:     if (done) nxt_state = nak ? S_STOP : ((op_ff == OP_WRITE) ? S_WHI : end_st);
      S_WHI:     if (done) nxt_state = nak ? S_STOP : S_WLO;
      S_WLO:     if (done) nxt_state = nak ? S_STOP : end_st;
      S_RHI:     if (done) nxt_state = (op_ff == OP_READ) ? S_RLO : end_st;
      S_RLO:     if (done) nxt_state = end_st;
      S_STOP:    if (done) nxt_state = S_IDLE;
    endcase
  end

  // Engine request per state
  assign bi.req      = !idle && !wait_ff;
  assign bi.hs       = hs_ff;
  assign bi.sda_in   = sda_s2_ff;
  assign bi.bop      = ((state_ff == S_HSSTART) || (state_ff == S_START)) ? BOP_START :
                       (state_ff == S_STOP) ? BOP_STOP :
                       ((state_ff == S_RHI) || (state_ff == S_RLO)) ? BOP_RBYTE : BOP_WBYTE;
  assign bi.tx       = (state_ff == S_HSCODE) ? {HS_CODE_TOP, hsc_ff} :
                       (state_ff == S_ADDR)   ? {slave, dir_rd} :
                       (state_ff == S_PTR)    ? ptr_ff :
                       (state_ff == S_WHI)    ? wdata_ff[15:8] : wdata_ff[7:0];
  // Upper byte acknowledged; last byte per setting; alert byte not acknowledged
  assign bi.ack_send = (state_ff == S_RHI) ? (op_ff == OP_READ) : lastack_ff;

  // Pins: output enable low drives the line low
  assign scl_o      = 1'b0;
  assign sda_o      = 1'b0;
  assign scl_oe_n_o = bi.scl_rel;
  assign sda_oe_n_o = bi.sda_rel;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_ff;
  assign avs_readdata_o    = readdata_ff;

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      ack_ff      <= 1'b0;
      readdata_ff <= 32'h0;
    end else begin
      sda_s1_ff <= sda_i;
      sda_s2_ff <= sda_s1_ff;
      scl_s1_ff <= scl_i;
      scl_s2_ff <= scl_s1_ff;
      ack_ff    <= (avs_read_i || avs_write_i) && !ack_ff;
      if (avs_read_i && !ack_ff) begin
        readdata_ff <= rd_mux;
      end
    end
  end

  // Software settings
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      op_ff      <= OP_WRITE;
      hs_req_ff  <= 1'b0;
      hold_ff    <= 1'b0;
      lastack_ff <= 1'b0;
      addr_ff    <= TGT_ADDR_RST;
      ptr_ff     <= TGT_PTR_RST;
      hsc_ff     <= TGT_HSC_RST;
      wdata_ff   <= WDATA_RST;
    end else begin
      if (wr_ctl && idle) begin
        op_ff      <= mcmon_op_t'(avs_writedata_i[CTRL_OP +: 2]);
        hs_req_ff  <= avs_writedata_i[CTRL_HS];
        hold_ff    <= avs_writedata_i[CTRL_HOLD];
        lastack_ff <= avs_writedata_i[CTRL_LASTACK];
      end
      if (wr_tgt && idle && avs_byteenable_i[0]) addr_ff <= avs_writedata_i[TGT_ADDR +: 7];
      if (wr_tgt && idle && avs_byteenable_i[1]) ptr_ff <= avs_writedata_i[TGT_PTR +: 8];
      if (wr_tgt && idle && avs_byteenable_i[2]) hsc_ff <= avs_writedata_i[TGT_HSC +: 3];
      if (wr_dat && idle && avs_byteenable_i[0]) wdata_ff[7:0] <= avs_writedata_i[7:0];
      if (wr_dat && idle && avs_byteenable_i[1]) wdata_ff[15:8] <= avs_writedata_i[15:8];
    end
  end

  // Sequencer and status
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= S_IDLE;
      wait_ff  <= 1'b0;
      rdata_ff <= 16'h0;
      nack_ff  <= 1'b0;
      hs_ff    <= 1'b0;
      held_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wait_ff  <= bi.req ? 1'b1 : (done ? 1'b0 : wait_ff);
      if (done && state_ff == S_RHI) begin
        rdata_ff <= (op_ff == OP_READ) ? {bi.rx, rdata_ff[7:0]} : {8'h00, bi.rx};
      end
      if (done && state_ff == S_RLO) begin
        rdata_ff[7:0] <= bi.rx;
      end
      // A new refusal wins over a clear in the same cycle
      nack_ff <= set_nak || (nack_ff && !(wr_st && avs_writedata_i[ST_NACK]));
      if (done && state_ff == S_HSCODE) begin
        hs_ff <= 1'b1;
      end else if (stop_dn) begin
        hs_ff <= 1'b0;
      end
      if (stop_dn || (done && state_ff == S_START)) begin
        held_ff <= 1'b0;
      end else if (done && nxt_state == S_IDLE) begin
        held_ff <= 1'b1;
      end
    end
  end

  a_bus_one_wait: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("Waitrequest held longer than one cycle");
  a_ptr_after_addr: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    $rose(state_ff == S_PTR) |-> ($past(state_ff) == S_ADDR) && !dir_rd)
    else $error("Pointer byte not right after write address");
  a_ptr_every_write: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    (state_ff == S_ADDR && done && !nak && !dir_rd) |=> (state_ff == S_PTR) && bi.req)
    else $error("Write address not followed by pointer");
  a_word_order: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    $rose(state_ff == S_WLO) |-> ($past(state_ff) == S_WHI) && (op_ff == OP_WRITE))
    else $error("Lower data byte without upper byte");
  a_read_msb_first: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    $rose(state_ff == S_RLO) |-> ($past(state_ff) == S_RHI) && (rdata_ff[15:8] == $past(bi.rx)))
    else $error("Lower read byte before upper byte");
  a_hs_code_first: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    $rose(hs_ff) |-> ($past(state_ff) == S_HSCODE) && (state_ff == S_START))
    else $error("High-speed entered without master code");
  a_stop_ends_hs: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    stop_dn |=> !hs_ff && !held_ff && (state_ff == S_IDLE))
    else $error("Stop did not end high-speed mode");
  a_hs_code_slow: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    (state_ff == S_HSCODE) |-> !bi.hs && (bi.tx[7:3] == HS_CODE_TOP))
    else $error("Master code not at slow rate");
  a_read_addr_dir: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    (state_ff == S_ADDR && op_ff == OP_READ) |-> (bi.tx == {addr_ff, 1'b1}))
    else $error("Read address without read direction");
  a_alert_addr: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    (state_ff == S_ADDR && op_ff == OP_ALERT) |-> (bi.tx == {ARA_ADDR, 1'b1}))
    else $error("Alert read not to response address");
  a_upper_acked: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    (state_ff == S_RHI && op_ff == OP_READ) |-> bi.ack_send)
    else $error("Upper read byte not acknowledged");
  a_nack_sticky: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    set_nak |=> nack_ff)
    else $error("Refused byte not flagged");
  a_ptr_from_target: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    (state_ff == S_PTR) |-> (bi.tx == ptr_ff) && (bi.bop == BOP_WBYTE))
    else $error("Pointer byte differs from target");
  a_settings_frozen: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    (busy && $past(busy)) |-> $stable(wdata_ff) && $stable(ptr_ff))
    else $error("Transfer settings changed while busy");
endmodule
`default_nettype wire

// file: logic/mcmon_pkg.sv
/*
  Shared constants and types of the monitor two-wire host controller.
  Assumes a 100 MHz system clock and byte addressing on the register bus.
*/
`default_nettype none
package mcmon_pkg;
  // Clock and serial rates
  localparam int CLK_NS = 10;
  localparam int FS_KHZ = 400;
  localparam int HS_KHZ = 2940;
  // One SCL period is three phases: low, low, high
  localparam int FS_PH = (1000000 + FS_KHZ * 3 * CLK_NS - 1) / (FS_KHZ * 3 * CLK_NS);
  localparam int HS_PH = (1000000 + HS_KHZ * 3 * CLK_NS - 1) / (HS_KHZ * 3 * CLK_NS);

  // Own register map, byte offsets
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_TARGET = 5'h04;
  localparam logic [4:0] REG_WDATA  = 5'h08;
  localparam logic [4:0] REG_RDATA  = 5'h0c;
  localparam logic [4:0] REG_STATUS = 5'h10;
  localparam int CTRL_GO      = 0;
  localparam int CTRL_OP      = 1;
  localparam int CTRL_HS      = 3;
  localparam int CTRL_HOLD    = 4;
  localparam int CTRL_LASTACK = 5;
  localparam int TGT_ADDR     = 0;
  localparam int TGT_PTR      = 8;
  localparam int TGT_HSC      = 16;
  localparam int ST_BUSY      = 0;
  localparam int ST_NACK      = 1;
  localparam int ST_HS        = 2;
  localparam int ST_HELD      = 3;
  localparam int ST_SDA       = 4;
  localparam int ST_SCL       = 5;
  localparam logic [6:0] TGT_ADDR_RST = 7'h40;
  localparam logic [7:0] TGT_PTR_RST  = 8'h00;
  localparam logic [2:0] TGT_HSC_RST  = 3'h0;
  localparam logic [15:0] WDATA_RST   = 16'h0000;

  // Monitor device map
  localparam logic [6:0] ARA_ADDR     = 7'h0c;
  localparam logic [4:0] HS_CODE_TOP  = 5'h01;
  localparam logic [7:0] PTR_CONFIG   = 8'h00;
  localparam logic [7:0] PTR_CURRENT  = 8'h01;
  localparam logic [7:0] PTR_VOLTAGE  = 8'h02;
  localparam logic [7:0] PTR_POWER    = 8'h03;
  localparam logic [7:0] PTR_MASK     = 8'h06;
  localparam logic [7:0] PTR_LIMIT    = 8'h07;
  localparam logic [7:0] PTR_MAKER    = 8'hfe;
  localparam logic [7:0] PTR_DIE      = 8'hff;
  localparam logic [15:0] CONFIG_RST  = 16'h6127;

  typedef enum logic [1:0] {OP_WRITE, OP_SETPTR, OP_READ, OP_ALERT} mcmon_op_t;
  typedef enum logic [1:0] {BOP_START, BOP_STOP, BOP_WBYTE, BOP_RBYTE} mcmon_bop_t;
endpackage
`default_nettype wire

// file: verification/mcmon_dev_model.sv
/*
  Behavioural monitor device on the two-wire bus, slave side.
  Assumes pulled-up SCL and SDA levels worked out by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module mcmon_dev_model
  import mcmon_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR = 7'h40,
  parameter logic [15:0] MAKER_ID = 16'h1a2b, // Arbitrary value
  parameter logic [15:0] DIE_ID   = 16'h3c4d, // Arbitrary value
  parameter int          TOUT_NS  = 28000000
) (
  // Bus lines
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_oe_n_o = 1'b1,
  // Alert source and line
  input  wire logic fault_i,
  output logic      alert_n_o
);
  logic [15:0] regs_ff [8] = '{CONFIG_RST, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [7:0]  ptr_ff  = 8'h00;
  logic [7:0]  sh_ff   = 8'h00;
  logic [7:0]  hi_ff   = 8'h00;
  logic [15:0] word_ff = 16'h0000;
  int          bit_ff  = 0;
  int          byte_ff = 0;
  int          conv_ff = 0;
  logic        act_ff  = 0, sel_ff = 0, rd_ff = 0, ara_ff = 0, snd_ff = 0;
  logic        hs_ff   = 0, flag_ff = 0, won_ff = 0;

  assign alert_n_o = !(flag_ff && !won_ff);

  // Reads never touch state
  function automatic logic [15:0] rd_word(input logic [7:0] p);
    case (p)
      PTR_CONFIG, PTR_CURRENT, PTR_VOLTAGE, PTR_POWER, PTR_MASK, PTR_LIMIT: return regs_ff[p[2:0]];
      PTR_MAKER: return MAKER_ID;
      PTR_DIE:   return DIE_ID;
      default:   return 16'h0000;
    endcase
  endfunction

  task automatic wr_word(input logic [15:0] w);
    case (ptr_ff)
      PTR_CONFIG: begin
        regs_ff[0] = w;
        conv_ff++;
      end
      PTR_MASK, PTR_LIMIT: regs_ff[ptr_ff[2:0]] = w;
      default: ;
    endcase
  endtask

  task automatic take_byte();
    if (byte_ff == 0) begin
      sel_ff = (sh_ff[7:1] == DEV_ADDR);
      rd_ff = sh_ff[0];
      ara_ff = (sh_ff == {ARA_ADDR, 1'b1}) && flag_ff && !won_ff;
      if (sh_ff[7:3] == HS_CODE_TOP) hs_ff = 1'b1;
      snd_ff = rd_ff && (sel_ff || ara_ff);
      word_ff = ara_ff ? {DEV_ADDR, 1'b0, 8'hff} : rd_word(ptr_ff);
    end else if (sel_ff && !rd_ff) begin
      if (byte_ff == 1) ptr_ff = sh_ff;
      if (byte_ff == 2) hi_ff = sh_ff;
      if (byte_ff == 3) wr_word({hi_ff, sh_ff});
    end
  endtask

  always @(posedge fault_i) begin
    flag_ff = 1'b1;
    won_ff = 1'b0;
  end

  // Start and stop framing
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    act_ff = 1'b1;
    bit_ff = 0;
    byte_ff = 0;
    snd_ff = 1'b0;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) begin
    act_ff = 1'b0;
    hs_ff = 1'b0;
  end

  always @(posedge scl_i) if (act_ff) begin
    if (bit_ff < 8) begin
      if (snd_ff && sda_oe_n_o && !sda_i) snd_ff = 1'b0;
      sh_ff = {sh_ff[6:0], sda_i};
      bit_ff++;
      if (bit_ff == 8) take_byte();
    end else begin
      if (ara_ff && byte_ff == 1 && snd_ff) won_ff = 1'b1;
      if (rd_ff && sda_i) snd_ff = 1'b0;
      bit_ff = 0;
      byte_ff++;
    end
  end

  // Bus timeout: SCL held low too long drops the frame
  always @(negedge scl_i) begin
    #(TOUT_NS) if (scl_i === 1'b0) act_ff = 1'b0;
  end

  // Change drive only on SCL falling edges, then hold it through the high phase
  always @(negedge scl_i) begin
    if (!act_ff) sda_oe_n_o = 1'b1;
    else if (bit_ff == 8) sda_oe_n_o = !(byte_ff == 0 ? (sel_ff || ara_ff) : (sel_ff && !rd_ff));
    else if (snd_ff && byte_ff == 1) sda_oe_n_o = word_ff[15 - bit_ff];
    else if (snd_ff && byte_ff == 2) sda_oe_n_o = word_ff[7 - bit_ff];
    else sda_oe_n_o = 1'b1;
  end
endmodule
`default_nettype wire

// file: verification/tb_monitor_i2c_register_access.sv
/*
  Self-checking bench of the monitor two-wire host controller.
  Assumes the device model on the far side and pullups on both lines.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_monitor_i2c_register_access;
  import mcmon_pkg::*;
  localparam logic [15:0] MAKER_ID = 16'h1a2b; // Arbitrary value
  localparam logic [15:0] DIE_ID   = 16'h3c4d; // Arbitrary value
  logic        ref_clk_i = 0;
  logic        reset_i = 1;
  logic [4:0]  avs_address_i = 5'h00;
  logic        avs_read_i = 0;
  logic        avs_write_i = 0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        scl_oe_n, sda_oe_n, dev_sda_oe_n, alert_n, scl_out, sda_out;
  logic        fault = 0;
  wire         scl_line = scl_oe_n | scl_out;
  wire         sda_line = (sda_oe_n | sda_out) & dev_sda_oe_n;
  int          mismatches = 0;
  int          n_checks = 0;
  logic [31:0] q;
  logic [4:0]  r_off [6] = '{REG_CTRL, REG_TARGET, REG_WDATA, REG_RDATA, REG_STATUS, 5'h14};
  logic [31:0] r_rst [6] = '{32'h0, 32'h40, 32'h0, 32'h0, 32'h30, 32'h0};
  logic [7:0]  p_tab [8] = '{PTR_CONFIG, PTR_CURRENT, PTR_VOLTAGE, PTR_POWER,
                             PTR_MASK, PTR_LIMIT, PTR_MAKER, PTR_DIE};
  logic [15:0] p_exp [8] = '{CONFIG_RST, 16'h0, 16'h0, 16'h0, 16'h0, 16'ha55a, MAKER_ID, DIE_ID};

  mcmon_i2c_host #(.FS_LEN(11), .HS_LEN(8)) u_dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hf), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .scl_i(scl_line), .scl_o(scl_out),
    .scl_oe_n_o(scl_oe_n), .sda_i(sda_line), .sda_o(sda_out), .sda_oe_n_o(sda_oe_n));
  mcmon_dev_model #(.MAKER_ID(MAKER_ID), .DIE_ID(DIE_ID)) u_dev (
    .scl_i(scl_line), .sda_i(sda_line), .sda_oe_n_o(dev_sda_oe_n), .fault_i(fault),
    .alert_n_o(alert_n));

  always #5 ref_clk_i = ~ref_clk_i;

  task automatic tally_and_finish();
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    bound(n, 20);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      av(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (q[ST_BUSY] !== 1'b0 && n < 3000);
    bound(n, 3000);
  endtask

  task automatic start(input mcmon_op_t op, input logic hs, input logic hold);
    av(1'b1, REG_CTRL, (32'(hold) << CTRL_HOLD) | (32'(hs) << CTRL_HS) | (32'(op) << CTRL_OP) | 32'h1);
  endtask

  task automatic go(input mcmon_op_t op, input logic hs, input logic hold);
    start(op, hs, hold);
    wait_idle();
  endtask

  task automatic tgt(input logic [6:0] a, input logic [7:0] p, input logic [2:0] c);
    av(1'b1, REG_TARGET, {13'h0, c, p, 1'b0, a});
  endtask

  task automatic st(input logic [31:0] m, input logic [31:0] e);
    av(1'b0, REG_STATUS, 32'h0);
    chk(q & m, e);
  endtask

  task automatic rdata(input logic [31:0] e);
    av(1'b0, REG_RDATA, 32'h0);
    chk(q, e);
  endtask

  initial begin
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      av(1'b0, r_off[i], 32'h0);
      chk(q, r_rst[i]);
    end
    // Word write; WDATA write during busy is dropped
    tgt(7'h40, PTR_LIMIT, 3'h0);
    av(1'b1, REG_WDATA, 32'h0000a55a);
    start(OP_WRITE, 1'b0, 1'b0);
    av(1'b1, REG_WDATA, 32'h0000ffff);
    wait_idle();
    chk(q & 32'h2, 32'h0);
    chk({16'h0, u_dev.regs_ff[7]}, 32'h0000a55a);
    av(1'b0, REG_WDATA, 32'h0);
    chk(q, 32'h0000a55a);
    // Pointer write with repeated start, then word read
    for (int i = 0; i < 8; i++) begin
      tgt(7'h40, p_tab[i], 3'h0);
      go(OP_SETPTR, 1'b0, 1'b1);
      st(32'ha, 32'h8);
      go(OP_READ, 1'b0, 1'b0);
      rdata({16'h0, p_exp[i]});
    end
    av(1'b1, REG_CTRL, 32'h25);
    wait_idle();
    rdata({16'h0, DIE_ID});
    // Write to a read-only register, pointer kept for read
    tgt(7'h40, PTR_CURRENT, 3'h0);
    av(1'b1, REG_WDATA, 32'h00001234);
    go(OP_WRITE, 1'b0, 1'b0);
    go(OP_READ, 1'b0, 1'b0);
    rdata(32'h0);
    // Unanswered address gives sticky nack
    tgt(7'h41, PTR_LIMIT, 3'h0);
    go(OP_WRITE, 1'b0, 1'b0);
    st(32'h3, 32'h2);
    chk({16'h0, u_dev.regs_ff[7]}, 32'h0000a55a);
    av(1'b1, REG_STATUS, 32'h2);
    st(32'h2, 32'h0);
    // High-speed entry, kept by repeated start, ended by stop
    tgt(7'h40, PTR_MAKER, 3'h5);
    go(OP_SETPTR, 1'b1, 1'b1);
    st(32'h6, 32'h4);
    chk({31'h0, u_dev.hs_ff}, 32'h1);
    go(OP_READ, 1'b1, 1'b0);
    rdata({16'h0, MAKER_ID});
    st(32'h6, 32'h0);
    chk({31'h0, u_dev.hs_ff}, 32'h0);
    // Alert response without and with a pending alert
    go(OP_ALERT, 1'b0, 1'b0);
    st(32'h2, 32'h2);
    av(1'b1, REG_STATUS, 32'h2);
    @(posedge ref_clk_i);
    fault <= 1'b1;
    @(posedge ref_clk_i);
    chk({31'h0, alert_n}, 32'h0);
    go(OP_ALERT, 1'b0, 1'b0);
    st(32'h2, 32'h0);
    rdata({24'h0, 7'h40, 1'b0});
    chk({30'h0, alert_n, u_dev.flag_ff}, 32'h3);
    tally_and_finish();
  end

  initial begin
    #900000;
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
